// ### ims_pkg.sv
/*
  shared constants for the interrupt scheme selector and acceptor: source
  vectors, priority field layout, register offsets and reset values.
  assumes one system clock shared by controller and cpu end.
*/
`default_nettype none
package ims_pkg;
  // number of maskable sources handled by this controller
  localparam int NSRC = 7;
  // number of priority fields in source_priority_reg
  localparam int NFLD = 3;
  // vector numbers of the maskable sources, index 0 wins fixed ordering
  localparam logic [7:0] IMS_SRC_VEC [0:NSRC-1] = '{8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE3, 8'hE4, 8'hE5};
  // which priority field each source reads
  localparam logic [1:0] IMS_SRC_FLD [0:NSRC-1] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
  // bit position of each priority field
  localparam int IMS_FLD_POS [0:NFLD-1] = '{0, 4, 8};
  // first vector number of the reserved upper range
  localparam logic [7:0] IMS_RSV_FIRST = 8'hD6;
  // vector of the non-maskable request (plain default)
  localparam logic [7:0] IMS_NMI_VEC = 8'h07;
  // mask level forced by the non-maskable request
  localparam logic [2:0] IMS_NMI_LVL = 3'h7;
  // scheme codes
  localparam logic [1:0] IMS_SCHEME0 = 2'h0;
  localparam logic [1:0] IMS_SCHEME2 = 2'h2;
  // register byte offsets
  localparam logic [4:0] IMS_OFF_SCHEME = 5'h00;
  localparam logic [4:0] IMS_OFF_ENABLE = 5'h04;
  localparam logic [4:0] IMS_OFF_PRIO   = 5'h08;
  localparam logic [4:0] IMS_OFF_PEND   = 5'h0C;
  localparam logic [4:0] IMS_OFF_STAT   = 5'h10;
  // reset values
  localparam logic [1:0]  IMS_RST_SCHEME = 2'h0;
  localparam logic [6:0]  IMS_RST_ENABLE = 7'h00;
  localparam logic [10:0] IMS_RST_PRIO   = 11'h777;
  // axi responses
  localparam logic [1:0] IMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IMS_RESP_SLVERR = 2'h2;
  // table entry spacing as shift of the vector number
  localparam int IMS_VEC_SHIFT = 2;
  // reserved vector check: upper range with no source attached
  function automatic logic ims_vec_reserved(input logic [7:0] v);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (IMS_SRC_VEC[i] == v)
      begin
        hit = 1'b1;
      end
    end
    return (v >= IMS_RSV_FIRST) && !hit;
  endfunction
endpackage
`default_nettype wire

// ### ims_link_if.sv
/*
  link between the interrupt controller and the cpu exception logic.
  assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
interface ims_link_if;
  logic       irq_req;      // a request is offered to the cpu
  logic [7:0] irq_vec;      // vector of the offered request
  logic [2:0] irq_lvl;      // priority of the offered request
  logic       irq_nmi;      // offered request is non-maskable
  logic       irq_scheme2;  // controller runs scheme 2
  logic       ack;          // one-cycle pulse: cpu accepted irq_vec
  logic [7:0] ack_vec;      // vector accepted
  logic       gmask;        // cpu global mask flag
  logic [2:0] mask_lvl;     // cpu priority_mask_level
  modport ctrl (output irq_req, irq_vec, irq_lvl, irq_nmi, irq_scheme2, input ack, ack_vec, gmask, mask_lvl);
  modport cpu  (input irq_req, irq_vec, irq_lvl, irq_nmi, irq_scheme2, output ack, ack_vec, gmask, mask_lvl);
endinterface
`default_nettype wire

// ### ims_arbiter.sv
/*
  combinational arbiter: picks the winning pending source and decides
  whether it passes the cpu mask. assumes inputs from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ims_arbiter
  import ims_pkg::*;
(
  input  wire logic [NSRC-1:0]   pend,
  input  wire logic [3*NSRC-1:0] lvl,
  input  wire logic              scheme2,
  input  wire logic              gmask,
  input  wire logic [2:0]        mask_lvl,
  output logic                   found,
  output logic [2:0]             win_idx,
  output logic [2:0]             win_lvl
);
  logic any; // some source is pending

  // scan from lowest ordering up so the lower index wins ties
  always_comb
  begin
    any     = 1'b0;
    win_idx = 3'h0;
    win_lvl = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        if (!scheme2 || !any || (lvl[3*i +: 3] >= win_lvl)) // RULE4 RULE17 RULE10
        begin
          any     = 1'b1;
          win_idx = 3'(i);
          win_lvl = scheme2 ? lvl[3*i +: 3] : 3'h0; // RULE5
        end
      end
    end
    // masking stage
    if (scheme2)
    begin
      found = any && (win_lvl > mask_lvl); // RULE6 RULE16
    end
    else
    begin
      found = any && !gmask; // RULE8 RULE9
    end
  end
endmodule
`default_nettype wire

// ### ims_ctrl.sv
/*
  interrupt controller end: register file on axi4-lite, pending flags,
  scheme select, arbitration and offer of one request to the cpu.
  assumes peripheral events and the link on the same clock as clk.
*/
// Overview of operation
// RULE1: table entries four bytes, low 16 bits
// RULE2: vectors from 214 without source are reserved
// RULE3: two schemes, 0 and 2, software selected
// RULE4: scheme 0 uses fixed built-in ordering
// RULE5: scheme 2 gives eight programmable levels
// RULE6: scheme 2 masks against three-bit level
// RULE7: events become requests only when enabled
// RULE8: scheme 0 mask set: only non-maskable
// RULE9: scheme 0 mask clear: maskable accepted
// RULE10: only highest priority passed, others pending
// RULE11: cpu waits for current instruction end
// RULE12: scheme 0 cpu stacks counter and flags
// RULE13: stacked counter is the return address
// RULE14: scheme 0 cpu sets mask after stacking
// RULE15: vector becomes table address, handler fetched
// RULE16: scheme 2 accepts only above mask
// RULE17: equal levels fall back to fixed ordering
// RULE18: scheme 2 stacks extended reg, sets level
// RULE19: non-maskable sets mask level seven
// RULE20: pending held until accepted or disabled
`timescale 1ns/1ps
`default_nettype none
module ims_ctrl
  import ims_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            ce,
  // axi4-lite slave
  input  wire logic [4:0]      s_awaddr,
  input  wire logic            s_awvalid,
  output logic                 s_awready,
  input  wire logic [31:0]     s_wdata,
  input  wire logic [3:0]      s_wstrb,
  input  wire logic            s_wvalid,
  output logic                 s_wready,
  output logic [1:0]           s_bresp,
  output logic                 s_bvalid,
  input  wire logic            s_bready,
  input  wire logic [4:0]      s_araddr,
  input  wire logic            s_arvalid,
  output logic                 s_arready,
  output logic [31:0]          s_rdata,
  output logic [1:0]           s_rresp,
  output logic                 s_rvalid,
  input  wire logic            s_rready,
  // peripheral events, one-cycle pulses
  input  wire logic [NSRC-1:0] src_event,
  input  wire logic            nmi_event,
  // link to the cpu
  ims_link_if.ctrl             link
);
  // registers
  logic [1:0]      scheme_q,  scheme_d;   // scheme_select_reg
  logic [NSRC-1:0] en_q,      en_d;       // per-source enables
  logic [10:0]     prio_q,    prio_d;     // source_priority_reg
  logic [NSRC-1:0] pend_q,    pend_d;     // pending flags
  logic            nmi_q,     nmi_d;      // nmi pending
  // bus state
  logic            awr_q,     awr_d;      // write address/data taken
  logic            bv_q,      bv_d;       // write response valid
  logic [1:0]      bresp_q,   bresp_d;    // write response code
  logic            arr_q,     arr_d;      // read address taken
  logic            rv_q,      rv_d;       // read data valid
  logic [31:0]     rdata_q,   rdata_d;    // read data
  logic [1:0]      rresp_q,   rresp_d;    // read response code
  // link outputs
  logic            req_q,     req_d;      // offered request
  logic [7:0]      vec_q,     vec_d;      // offered vector
  logic [2:0]      lvl_q,     lvl_d;      // offered level
  logic            onmi_q,    onmi_d;     // offered is nmi
  // arbiter wires
  logic [3*NSRC-1:0] src_lvl;             // level per source
  logic              found;               // maskable winner passes mask
  logic [2:0]        win_idx;             // winning source
  logic [2:0]        win_lvl;             // its level
  logic              wr_go;               // write performed this cycle

  // map each source onto its shared priority field
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_lvl
      assign src_lvl[3*g +: 3] = prio_q[IMS_FLD_POS[IMS_SRC_FLD[g]] +: 3]; // RULE5
    end
  endgenerate

  // winner selection
  ims_arbiter u_arb (
    .pend     (pend_q),
    .lvl      (src_lvl),
    .scheme2  (scheme_q == IMS_SCHEME2),
    .gmask    (link.gmask),
    .mask_lvl (link.mask_lvl),
    .found    (found),
    .win_idx  (win_idx),
    .win_lvl  (win_lvl)
  );

  assign wr_go = awr_q && s_awvalid && s_wvalid;

  // bus handshakes and register writes
  always_comb
  begin
    scheme_d = scheme_q;
    en_d     = en_q;
    prio_d   = prio_q;
    awr_d    = 1'b0;
    bv_d     = bv_q;
    bresp_d  = bresp_q;
    arr_d    = 1'b0;
    rv_d     = rv_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    // take address and data together, one write in flight
    if (s_awvalid && s_wvalid && !awr_q && !bv_q)
    begin
      awr_d = 1'b1;
    end
    if (wr_go)
    begin
      bv_d    = 1'b1;
      bresp_d = IMS_RESP_OKAY;
      case (s_awaddr)
        IMS_OFF_SCHEME:
        begin
          // only the two documented codes are stored
          if (s_wstrb[0] && (s_wdata[1:0] == IMS_SCHEME0 || s_wdata[1:0] == IMS_SCHEME2))
          begin
            scheme_d = s_wdata[1:0]; // RULE3
          end
        end
        IMS_OFF_ENABLE:
        begin
          if (s_wstrb[0])
          begin
            en_d = s_wdata[NSRC-1:0];
          end
        end
        IMS_OFF_PRIO:
        begin
          if (s_wstrb[0])
          begin
            prio_d[7:0] = s_wdata[7:0];
          end
          if (s_wstrb[1])
          begin
            prio_d[10:8] = s_wdata[10:8];
          end
          prio_d[3] = 1'b0;
          prio_d[7] = 1'b0;
        end
        IMS_OFF_PEND, IMS_OFF_STAT:
        begin
          bresp_d = IMS_RESP_OKAY; // read-only, write ignored
        end
        default:
        begin
          bresp_d = IMS_RESP_SLVERR; // unmapped
        end
      endcase
    end
    else if (bv_q && s_bready)
    begin
      bv_d = 1'b0;
    end
    // read channel, one read in flight
    if (s_arvalid && !arr_q && !rv_q)
    begin
      arr_d = 1'b1;
    end
    if (arr_q && s_arvalid)
    begin
      rv_d    = 1'b1;
      rresp_d = IMS_RESP_OKAY;
      case (s_araddr)
        IMS_OFF_SCHEME: rdata_d = {30'h00000000, scheme_q};
        IMS_OFF_ENABLE: rdata_d = {25'h0000000, en_q};
        IMS_OFF_PRIO:   rdata_d = {21'h000000, prio_q};
        IMS_OFF_PEND:   rdata_d = {23'h000000, nmi_q, 1'b0, pend_q};
        IMS_OFF_STAT:   rdata_d = {19'h00000, onmi_q, lvl_q, req_q, vec_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = IMS_RESP_SLVERR;
        end
      endcase
    end
    else if (rv_q && s_rready)
    begin
      rv_d = 1'b0;
    end
  end

  // pending flags: a new event beats a clear in the same cycle
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      pend_d[i] = pend_q[i] && en_d[i] // RULE20
                  && !(link.ack && link.ack_vec == IMS_SRC_VEC[i] && !ims_vec_reserved(IMS_SRC_VEC[i])); // RULE2
      if (src_event[i] && en_q[i])
      begin
        pend_d[i] = 1'b1; // RULE7
      end
    end
    nmi_d = (nmi_q && !(link.ack && link.ack_vec == IMS_NMI_VEC)) || nmi_event;
  end

  // offer to the cpu: nmi beats every maskable source
  always_comb
  begin
    req_d  = 1'b0;
    vec_d  = vec_q;
    lvl_d  = lvl_q;
    onmi_d = 1'b0;
    if (nmi_q)
    begin
      req_d  = 1'b1; // RULE8
      vec_d  = IMS_NMI_VEC;
      lvl_d  = IMS_NMI_LVL;
      onmi_d = 1'b1;
    end
    else if (found && !(link.ack && link.ack_vec == IMS_SRC_VEC[win_idx]))
    begin
      req_d = 1'b1; // RULE10
      vec_d = IMS_SRC_VEC[win_idx];
      lvl_d = win_lvl;
    end
  end

  // register stage, frozen while ce is low
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scheme_q <= IMS_RST_SCHEME;
      en_q     <= IMS_RST_ENABLE;
      prio_q   <= IMS_RST_PRIO;
      pend_q   <= '0;
      nmi_q    <= 1'b0;
      awr_q    <= 1'b0;
      bv_q     <= 1'b0;
      bresp_q  <= IMS_RESP_OKAY;
      arr_q    <= 1'b0;
      rv_q     <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= IMS_RESP_OKAY;
      req_q    <= 1'b0;
      vec_q    <= 8'h00;
      lvl_q    <= 3'h0;
      onmi_q   <= 1'b0;
    end
    else if (ce)
    begin
      scheme_q <= scheme_d;
      en_q     <= en_d;
      prio_q   <= prio_d;
      pend_q   <= pend_d;
      nmi_q    <= nmi_d;
      awr_q    <= awr_d;
      bv_q     <= bv_d;
      bresp_q  <= bresp_d;
      arr_q    <= arr_d;
      rv_q     <= rv_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      req_q    <= req_d;
      vec_q    <= vec_d;
      lvl_q    <= lvl_d;
      onmi_q   <= onmi_d;
    end
  end

  // ports straight from flops, except irq_scheme2 which is decoded from scheme_q
  assign s_awready        = awr_q;
  assign s_wready         = awr_q;
  assign s_bvalid         = bv_q;
  assign s_bresp          = bresp_q;
  assign s_arready        = arr_q;
  assign s_rvalid         = rv_q;
  assign s_rdata          = rdata_q;
  assign s_rresp          = rresp_q;
  assign link.irq_req     = req_q;
  assign link.irq_vec     = vec_q;
  assign link.irq_lvl     = lvl_q;
  assign link.irq_nmi     = onmi_q;
  assign link.irq_scheme2 = (scheme_q == IMS_SCHEME2);
endmodule
`default_nettype wire

// ### ims_cpu_end.sv
/*
  cpu exception end: accepts the offered request, waits for the current
  instruction, stacks state, updates masks and fetches the handler.
  assumes stack and table memory answer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ims_cpu_end
  import ims_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        instr_done,   // current instruction finished
  input  wire logic [31:0] return_pc,    // first instruction after return
  input  wire logic        ret_strobe,   // return from handler: restore flags
  input  wire logic        ret_gmask,
  input  wire logic [2:0]  ret_mask,
  output logic             push_valid,   // one word pushed
  output logic [31:0]      push_data,
  output logic             table_rd,     // table read request
  output logic [15:0]      table_addr,
  input  wire logic        table_valid,
  input  wire logic [15:0] table_data,
  output logic             handler_go,   // pulse: start at handler_addr
  output logic [15:0]      handler_addr,
  ims_link_if.cpu          link
);
  typedef enum logic [6:0] {
    C_IDLE = 7'h01, C_WAIT = 7'h02, C_PC = 7'h04, C_FLAGS = 7'h08,
    C_EXT = 7'h10, C_FETCH = 7'h20, C_GO = 7'h40
  } ims_cstate_t;
  ims_cstate_t st_q, st_d;                // sequence state
  logic        gmask_q, gmask_d;          // global mask flag
  logic [2:0]  mask_q, mask_d;            // priority_mask_level
  logic        trace_q, trace_d;          // trace bit of extended reg
  logic [7:0]  vec_q, vec_d;              // accepted vector
  logic [2:0]  lvl_q, lvl_d;              // accepted level
  logic        nmi_q, nmi_d;              // accepted is nmi
  logic        s2_q, s2_d;                // scheme 2 at acceptance
  logic        ack_q, ack_d;              // accept pulse
  logic        push_q, push_d;            // push strobe
  logic [31:0] pdata_q, pdata_d;          // push word
  logic        trd_q, trd_d;              // table read strobe
  logic        go_q, go_d;                // handler start pulse
  logic [15:0] haddr_q, haddr_d;          // handler address

  // acceptance and exception sequence
  always_comb
  begin
    st_d = st_q; gmask_d = gmask_q; mask_d = mask_q; trace_d = trace_q;
    vec_d = vec_q; lvl_d = lvl_q; nmi_d = nmi_q; s2_d = s2_q;
    ack_d = 1'b0; push_d = 1'b0; pdata_d = pdata_q; trd_d = 1'b0;
    go_d = 1'b0; haddr_d = haddr_q;
    case (st_q)
      C_IDLE:
      begin
        if (ret_strobe)
        begin
          gmask_d = ret_gmask;
          mask_d  = ret_mask;
        end
        else if (link.irq_req)
        begin
          ack_d = 1'b1;
          vec_d = link.irq_vec;
          lvl_d = link.irq_lvl;
          nmi_d = link.irq_nmi;
          s2_d  = link.irq_scheme2;
          st_d  = C_WAIT;
        end
      end
      C_WAIT:
      begin
        if (instr_done)
        begin
          st_d = C_PC; // RULE11
        end
      end
      C_PC:
      begin
        push_d  = 1'b1;
        pdata_d = return_pc; // RULE12 RULE13
        st_d    = C_FLAGS;
      end
      C_FLAGS:
      begin
        push_d  = 1'b1;
        pdata_d = {24'h000000, gmask_q, 7'h00};
        st_d    = s2_q ? C_EXT : C_FETCH;
        if (!s2_q)
        begin
          gmask_d = 1'b1; // RULE14
        end
      end
      C_EXT:
      begin
        push_d  = 1'b1;
        pdata_d = {24'h000000, trace_q, 4'h0, mask_q};
        trace_d = 1'b0; // RULE18
        mask_d  = nmi_q ? IMS_NMI_LVL : lvl_q; // RULE19
        st_d    = C_FETCH;
      end
      C_FETCH:
      begin
        trd_d = !trd_q && !table_valid;
        if (table_valid)
        begin
          haddr_d = table_data; // RULE1 RULE15
          st_d    = C_GO;
        end
      end
      C_GO:
      begin
        go_d = 1'b1;
        st_d = C_IDLE;
      end
      default:
      begin
        st_d = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= C_IDLE; gmask_q <= 1'b1; mask_q <= IMS_NMI_LVL; trace_q <= 1'b0;
      vec_q <= 8'h00; lvl_q <= 3'h0; nmi_q <= 1'b0; s2_q <= 1'b0;
      ack_q <= 1'b0; push_q <= 1'b0; pdata_q <= 32'h00000000; trd_q <= 1'b0;
      go_q <= 1'b0; haddr_q <= 16'h0000;
    end
    else if (ce)
    begin
      st_q <= st_d; gmask_q <= gmask_d; mask_q <= mask_d; trace_q <= trace_d;
      vec_q <= vec_d; lvl_q <= lvl_d; nmi_q <= nmi_d; s2_q <= s2_d;
      ack_q <= ack_d; push_q <= push_d; pdata_q <= pdata_d; trd_q <= trd_d;
      go_q <= go_d; haddr_q <= haddr_d;
    end
  end

  // vector times four gives the table entry
  assign table_addr    = {6'h00, vec_q, 2'h0} ; // RULE1 RULE15
  assign push_valid    = push_q;
  assign push_data     = pdata_q;
  assign table_rd      = trd_q;
  assign handler_go    = go_q;
  assign handler_addr  = haddr_q;
  assign link.ack      = ack_q;
  assign link.ack_vec  = vec_q;
  assign link.gmask    = gmask_q;
  assign link.mask_lvl = mask_q;
endmodule
`default_nettype wire

// ### ims_link_assertions.sv
/*
  checks on the link between controller and cpu end.
  assumes one clock and an active-high reset from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ims_link_assertions
  import ims_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       irq_req,
  input wire logic [7:0] irq_vec,
  input wire logic [2:0] irq_lvl,
  input wire logic       irq_nmi,
  input wire logic       irq_scheme2,
  input wire logic       ack,
  input wire logic [7:0] ack_vec,
  input wire logic       gmask,
  input wire logic [2:0] mask_lvl
);
  logic [2:0] acc_q;  // level of the last accepted offer
  // keep the level that stood on the link when the cpu accepted
  always_ff @(posedge clk)
  begin
    if (ack)
    begin
      acc_q <= $past(irq_lvl);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // acceptance in each scheme
  sequence s_acc0; ack && !irq_scheme2; endsequence
  sequence s_acc2; ack && irq_scheme2; endsequence
  property p_mask0;
    !irq_scheme2 && !$past(irq_scheme2) && $past(gmask) && irq_req |-> irq_nmi;
  endproperty
  a_mask0: assert property (p_mask0) else $error("maskable offered under mask flag");
  property p_lvl2;
    irq_scheme2 && $past(irq_scheme2) && irq_req && !irq_nmi |-> irq_lvl > $past(mask_lvl);
  endproperty
  a_lvl2: assert property (p_lvl2) else $error("offer not above mask level");
  property p_nmi;
    irq_req && irq_nmi |-> irq_vec == IMS_NMI_VEC && irq_lvl == IMS_NMI_LVL;
  endproperty
  a_nmi: assert property (p_nmi) else $error("non-maskable offer malformed");
  property p_vec;
    irq_req && !irq_nmi |-> irq_vec inside {8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE3, 8'hE4, 8'hE5};
  endproperty
  a_vec: assert property (p_vec) else $error("offered vector has no source");
  property p_ack;
    ack |-> $past(irq_req) && ack_vec == $past(irq_vec);
  endproperty
  a_ack: assert property (p_ack) else $error("accepted vector differs from offer");
  property p_gap;
    ack |=> !ack [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("second accept during handling");
  property p_msk0;
    s_acc0 |-> ##[2:60] gmask;
  endproperty
  a_msk0: assert property (p_msk0) else $error("mask flag not set");
  property p_lvl;
    s_acc2 |-> ##[3:60] mask_lvl == acc_q;
  endproperty
  a_lvl: assert property (p_lvl) else $error("mask level not loaded");
endmodule
`default_nettype wire

// ### tb.sv
/*
  bench: controller and cpu end joined by the link, axi4-lite master,
  table memory stand-in. assumes the shared package.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ims_pkg::*;
  typedef struct {logic [1:0] s; logic [6:0] e; logic [10:0] p; logic [6:0] x;
                  logic [2:0] m; logic [7:0] v; logic [2:0] l;} ims_row_t;
  // scheme, enables, priorities, events, mask, expected vector and level
  ims_row_t rows [6] = '{'{2'h0, 7'h7F, 11'h777, 7'h60, 3'h0, 8'hE4, 3'h0},
                         '{2'h0, 7'h7E, 11'h777, 7'h03, 3'h0, 8'hDD, 3'h0},
                         '{2'h2, 7'h7F, 11'h351, 7'h51, 3'h0, 8'hE3, 3'h5},
                         '{2'h2, 7'h7F, 11'h333, 7'h60, 3'h2, 8'hE4, 3'h3},
                         '{2'h2, 7'h7F, 11'h124, 7'h30, 3'h1, 8'hE3, 3'h2},
                         '{2'h0, 7'h7F, 11'h777, 7'h08, 3'h0, 8'hDF, 3'h0}};
  logic clk, reset, ce, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, nmi_event, instr_done, ret_strobe, ret_gmask;
  logic push_valid, table_rd, table_valid, handler_go;
  logic [4:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, return_pc, push_data;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic [6:0] src_event;
  logic [2:0] ret_mask;
  logic [15:0] table_addr, table_data, handler_addr, h;
  logic [31:0] pushes [$];  // words pushed by the cpu end
  int err_count, checks_done, early;
  ims_link_if lnk ();
  ims_ctrl i_ims_ctrl (.clk, .reset, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .src_event, .nmi_event, .link(lnk));
  ims_cpu_end i_ims_cpu_end (.clk, .reset, .ce, .instr_done, .return_pc, .ret_strobe, .ret_gmask,
    .ret_mask, .push_valid, .push_data, .table_rd, .table_addr, .table_valid, .table_data,
    .handler_go, .handler_addr, .link(lnk));
  ims_link_assertions u_chk (.clk, .reset, .irq_req(lnk.irq_req), .irq_vec(lnk.irq_vec),
    .irq_lvl(lnk.irq_lvl), .irq_nmi(lnk.irq_nmi), .irq_scheme2(lnk.irq_scheme2), .ack(lnk.ack),
    .ack_vec(lnk.ack_vec), .gmask(lnk.gmask), .mask_lvl(lnk.mask_lvl));
  always #2 clk = ~clk;
  // table memory answers a cycle after the read
  always @(posedge clk)
  begin
    table_valid <= table_rd;
    table_data <= table_addr ^ 16'hA5A5;
    if (push_valid)
    begin
      pushes.push_back(push_data);
      early += !instr_done;
    end
  end
  function automatic logic [15:0] hx(input logic [7:0] v);
    return {6'h00, v, 2'h0} ^ 16'hA5A5;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one axi4-lite write or read, response and read data compared
  task automatic axi(input bit wr, input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w, b;
    logic [1:0] rs;
    logic [31:0] rd;
    int n;
    aw = 1;
    w = wr;
    b = 1;
    n = 0;
    @(posedge clk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_bready <= wr;
    s_arvalid <= !wr;
    s_rready <= !wr;
    while (b && n < 50)
    begin
      @(posedge clk);
      n++;
      if (wr && aw && s_awready)
      begin
        aw = 0;
        s_awvalid <= 0;
      end
      if (w && s_wready)
      begin
        w = 0;
        s_wvalid <= 0;
      end
      if (!wr && aw && s_arready)
      begin
        aw = 0;
        s_arvalid <= 0;
      end
      if (wr && s_bvalid)
      begin
        b = 0;
        rs = s_bresp;
        s_bready <= 0;
      end
      if (!wr && s_rvalid)
      begin
        b = 0;
        rs = s_rresp;
        rd = s_rdata;
        s_rready <= 0;
      end
    end
    if (b)
    begin
      err_count++;
      report_and_stop();
    end
    chk("resp", 32'(rs), 32'(er));
    if (!wr)
      chk("rdata", rd, d);
  endtask
  task automatic ev(input logic [6:0] e, input logic n);
    @(posedge clk);
    src_event <= e;
    nmi_event <= n;
    @(posedge clk);
    src_event <= '0;
    nmi_event <= 0;
  endtask
  task automatic ret(input logic c, input logic [2:0] m);
    @(posedge clk);
    ret_strobe <= 1;
    ret_gmask <= c;
    ret_mask <= m;
    @(posedge clk);
    ret_strobe <= 0;
  endtask
  // wait for handler start; instruction ends after five cycles
  task automatic wgo;
    int n;
    for (n = 1; n < 100 && !handler_go; n++)
    begin
      @(posedge clk);
      instr_done <= (n >= 5);
    end
    h = handler_addr;
    if (!handler_go)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  initial
  begin
    {clk, ce, reset, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 8'h07 << 5;
    {nmi_event, instr_done, ret_strobe, ret_gmask, src_event, ret_mask} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    return_pc = 32'h00004C20;
    repeat (2) @(posedge clk);
    reset <= 0;
    foreach (rows[i])
    begin
      axi(1, IMS_OFF_ENABLE, 32'h0, IMS_RESP_OKAY);
      ret(1, 3'h7);
      axi(1, IMS_OFF_SCHEME, 32'(rows[i].s), IMS_RESP_OKAY);
      axi(1, IMS_OFF_PRIO, 32'(rows[i].p), IMS_RESP_OKAY);
      axi(1, IMS_OFF_ENABLE, 32'(rows[i].e), IMS_RESP_OKAY);
      ev(rows[i].x, 0);
      repeat (3) @(posedge clk);
      pushes.delete();
      instr_done <= 0;
      ret(0, rows[i].m);
      wgo();
      chk("handler", 32'(h), 32'(hx(rows[i].v)));
      chk("pc", pushes[0], return_pc);
      chk("pushes", 32'(pushes.size()), rows[i].s == IMS_SCHEME2 ? 32'h3 : 32'h2);
      if (rows[i].s == IMS_SCHEME2)
      begin
        chk("ext", 32'(pushes[2][2:0]), 32'(rows[i].m));
        chk("mask", 32'(lnk.mask_lvl), 32'(rows[i].l));
      end
      else
        chk("flag", 32'(lnk.gmask), 32'h1);
    end
    // masked maskable stays pending while the non-maskable passes
    axi(1, IMS_OFF_ENABLE, 32'h0, IMS_RESP_OKAY);
    ret(1, 3'h7);
    axi(1, IMS_OFF_SCHEME, 32'h0, IMS_RESP_OKAY);
    axi(1, IMS_OFF_ENABLE, 32'h7F, IMS_RESP_OKAY);
    ev(7'h04, 0);
    repeat (4) @(posedge clk);
    chk("irq_req", 32'(lnk.irq_req), 32'h0);
    axi(0, IMS_OFF_PEND, 32'h4, IMS_RESP_OKAY);
    instr_done <= 0;
    ev(7'h00, 1);
    wgo();
    chk("nmi", 32'(h), 32'(hx(IMS_NMI_VEC)));
    axi(0, IMS_OFF_PEND, 32'h4, IMS_RESP_OKAY);
    axi(1, IMS_OFF_ENABLE, 32'h0, IMS_RESP_OKAY);
    axi(0, IMS_OFF_PEND, 32'h0, IMS_RESP_OKAY);
    // non-maskable in scheme 2 forces the top mask level
    axi(1, IMS_OFF_SCHEME, 32'h2, IMS_RESP_OKAY);
    ret(1, 3'h3);
    pushes.delete();
    instr_done <= 0;
    ev(7'h00, 1);
    wgo();
    chk("nmi_mask", 32'(lnk.mask_lvl), 32'h7);
    chk("nmi_ext", 32'(pushes[2][2:0]), 32'h3);
    axi(1, IMS_OFF_SCHEME, 32'h1, IMS_RESP_OKAY);
    axi(0, IMS_OFF_SCHEME, 32'h2, IMS_RESP_OKAY);
    axi(1, 5'h14, 32'h1, IMS_RESP_SLVERR);
    axi(0, 5'h14, 32'h0, IMS_RESP_SLVERR);
    // second reset in mid-run
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk("rst_flag", 32'(lnk.gmask), 32'h1);
    chk("rst_mask", 32'(lnk.mask_lvl), 32'h7);
    axi(0, IMS_OFF_SCHEME, 32'h0, IMS_RESP_OKAY);
    axi(0, IMS_OFF_PRIO, 32'h777, IMS_RESP_OKAY);
    chk("early", 32'(early), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
